// file: pghj_consts.vh
// Constants for the port G/H/J alternate-function override block.
// Assumes inclusion by bare name from the design file.
`ifndef PGHJ_CONSTS_VH
`define PGHJ_CONSTS_VH

// Port width
`define PGHJ_PORT_W        8
// AXI4-Lite register byte addresses
`define PGHJ_ADDR_G_DIR    6'h00
`define PGHJ_ADDR_G_VAL    6'h04
`define PGHJ_ADDR_H_DIR    6'h08
`define PGHJ_ADDR_H_VAL    6'h0C
`define PGHJ_ADDR_J_DIR    6'h10
`define PGHJ_ADDR_J_VAL    6'h14
`define PGHJ_ADDR_CTRL     6'h18
`define PGHJ_ADDR_G_PIN    6'h1C
`define PGHJ_ADDR_H_PIN    6'h20
`define PGHJ_ADDR_J_PIN    6'h24
`define PGHJ_ADDR_W        6
// Control register fields
`define PGHJ_CTRL_PUD      0
`define PGHJ_CTRL_SYNC2    1
`define PGHJ_CTRL_PCIE1    2
// Reset values
`define PGHJ_RST_BYTE      8'h00
`define PGHJ_RST_CTRL      3'h0
// AXI responses
`define PGHJ_RESP_OKAY     2'b00
`define PGHJ_RESP_SLVERR   2'b10

`endif

// file: pghj_pads.sv
// Board model for one 8-bit port of the override block.
// Assumes the bench gives the level of each pin's external source.
`timescale 1ns/100ps
`default_nettype none
module pghj_pads #(
  parameter W = 8
) (
  // Design side
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] pu,
  // Board side source level
  input  wire logic [W-1:0] ext,
  // Resolved pin level
  output wire logic [W-1:0] lvl
);
  // Design drive wins, then the pull-up, then the board source
  assign lvl = (oe & out) | (~oe & pu) | (~oe & ~pu & ext);
endmodule // pghj_pads
`default_nettype wire

// file: pghj_pin_mux.v
// Port G/H/J pin override logic with an AXI4-Lite register slave.
// Assumes peripherals drive override controls synchronous to aclk; pads
// resolve pin levels from the pad_*_oe, pad_*_out and pad_*_pullup outputs.
`timescale 1ns/100ps
`default_nettype none
`include "pghj_consts.vh"

module pghj_pin_mux #(
  parameter W = `PGHJ_PORT_W
) (
  // Clock and reset
  input  wire         aclk,
  input  wire         aresetn,
  // AXI4-Lite write address, data and response
  input  wire [31:0]  s_axi_awaddr,
  input  wire         s_axi_awvalid,
  output reg          s_axi_awready,
  input  wire [31:0]  s_axi_wdata,
  input  wire [3:0]   s_axi_wstrb,
  input  wire         s_axi_wvalid,
  output reg          s_axi_wready,
  output reg  [1:0]   s_axi_bresp,
  output reg          s_axi_bvalid,
  input  wire         s_axi_bready,
  // AXI4-Lite read
  input  wire [31:0]  s_axi_araddr,
  input  wire         s_axi_arvalid,
  output reg          s_axi_arready,
  output reg  [31:0]  s_axi_rdata,
  output reg  [1:0]   s_axi_rresp,
  output reg          s_axi_rvalid,
  input  wire         s_axi_rready,
  // Pads
  input  wire [W-1:0] pad_g_in,
  input  wire [W-1:0] pad_h_in,
  input  wire [W-1:0] pad_j_in,
  output reg  [W-1:0] pad_g_out,
  output reg  [W-1:0] pad_g_oe,
  output reg  [W-1:0] pad_g_pullup,
  output reg  [W-1:0] pad_h_out,
  output reg  [W-1:0] pad_h_oe,
  output reg  [W-1:0] pad_h_pullup,
  output reg  [W-1:0] pad_j_out,
  output reg  [W-1:0] pad_j_oe,
  output reg  [W-1:0] pad_j_pullup,
  // External memory interface
  input  wire         ext_mem_enable,
  input  wire         ext_mem_ale,
  input  wire         ext_mem_rd_strobe,
  input  wire         ext_mem_wr_strobe,
  // Timer oscillator, compare outputs and counting source
  input  wire         async_timer_clk_sel,
  input  wire         ext_clock_sel,
  output reg          timer_osc_in,
  input  wire         timer_osc_out,
  output reg          timer_osc_out_oe,
  input  wire         timer0_cmp_b_en,
  input  wire         timer0_cmp_b_out,
  input  wire         timer2_cmp_b_en,
  input  wire         timer2_cmp_b_out,
  input  wire [2:0]   timer4_cmp_en,
  input  wire [2:0]   timer4_cmp_out,
  output reg          timer4_count_in,
  // Serial channel 2
  input  wire         serial2_clk_out_en,
  input  wire         serial2_clk,
  output reg          serial2_clk_in,
  input  wire         serial2_tx_enable,
  input  wire         serial2_tx,
  input  wire         serial2_rx_enable,
  output reg          serial2_rx,
  // Serial channel 3
  input  wire         serial3_clk_out_en,
  input  wire         serial3_clk,
  output reg          serial3_clk_in,
  input  wire         serial3_tx_enable,
  input  wire         serial3_tx,
  input  wire         serial3_rx_enable,
  output reg          serial3_rx,
  // Pin-change sources 15..9
  input  wire [6:0]   pin_change_mask,
  output reg  [6:0]   pin_change_src
);

  // ----------------------------------------------------------------
  // Port registers
  // ----------------------------------------------------------------
  reg  [W-1:0] g_dir_q, g_val_q, h_dir_q, h_val_q, j_dir_q, j_val_q;
  reg  [2:0]   ctrl_q;
  reg          aw_q, w_q, wlane_q;
  reg  [`PGHJ_ADDR_W-1:0] awaddr_q;
  reg  [31:0]  wdata_q;
  wire [W-1:0] g_oe, g_o, g_pu, g_ie, h_oe, h_o, h_pu, h_ie, j_oe, j_o, j_pu, j_ie;
  wire         global_pullup_disable    = ctrl_q[`PGHJ_CTRL_PUD];
  wire         sync2  = ctrl_q[`PGHJ_CTRL_SYNC2];
  wire         pcie1  = ctrl_q[`PGHJ_CTRL_PCIE1];
  wire         do_wr  = aw_q && w_q && !s_axi_bvalid;
  wire         wa_ok  = awaddr_q[1:0] == 2'b00 && awaddr_q <= `PGHJ_ADDR_CTRL;

  // Write channel: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= {`PGHJ_ADDR_W{1'b0}};
      wdata_q <= 32'h0000_0000;
      wlane_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PGHJ_RESP_OKAY;
      g_dir_q <= `PGHJ_RST_BYTE;
      g_val_q <= `PGHJ_RST_BYTE;
      h_dir_q <= `PGHJ_RST_BYTE;
      h_val_q <= `PGHJ_RST_BYTE;
      j_dir_q <= `PGHJ_RST_BYTE;
      j_val_q <= `PGHJ_RST_BYTE;
      ctrl_q <= `PGHJ_RST_CTRL;
    end else begin
      s_axi_awready <= !aw_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr[`PGHJ_ADDR_W-1:0];
      end
      if (s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wlane_q <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wa_ok ? `PGHJ_RESP_OKAY : `PGHJ_RESP_SLVERR;
        if (wlane_q) begin
          case (awaddr_q)
            `PGHJ_ADDR_G_DIR: g_dir_q <= wdata_q[W-1:0];
            `PGHJ_ADDR_G_VAL: g_val_q <= wdata_q[W-1:0];
            `PGHJ_ADDR_H_DIR: h_dir_q <= wdata_q[W-1:0];
            `PGHJ_ADDR_H_VAL: h_val_q <= wdata_q[W-1:0];
            `PGHJ_ADDR_J_DIR: j_dir_q <= wdata_q[W-1:0];
            `PGHJ_ADDR_J_VAL: j_val_q <= wdata_q[W-1:0];
            `PGHJ_ADDR_CTRL:  ctrl_q <= wdata_q[2:0];
            default: ;
          endcase
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  reg [31:0] rd_d;
  reg        rok_d;
  always @* begin
    rd_d = 32'h0000_0000;
    rok_d = 1'b1;
    case (s_axi_araddr[`PGHJ_ADDR_W-1:0])
      `PGHJ_ADDR_G_DIR: rd_d[W-1:0] = g_dir_q;
      `PGHJ_ADDR_G_VAL: rd_d[W-1:0] = g_val_q;
      `PGHJ_ADDR_H_DIR: rd_d[W-1:0] = h_dir_q;
      `PGHJ_ADDR_H_VAL: rd_d[W-1:0] = h_val_q;
      `PGHJ_ADDR_J_DIR: rd_d[W-1:0] = j_dir_q;
      `PGHJ_ADDR_J_VAL: rd_d[W-1:0] = j_val_q;
      `PGHJ_ADDR_CTRL:  rd_d[2:0] = ctrl_q;
      `PGHJ_ADDR_G_PIN: rd_d[W-1:0] = pad_g_in & g_ie;
      `PGHJ_ADDR_H_PIN: rd_d[W-1:0] = pad_h_in & h_ie;
      `PGHJ_ADDR_J_PIN: rd_d[W-1:0] = pad_j_in & j_ie;
      default:          rok_d = 1'b0;
    endcase
    if (s_axi_araddr[31:`PGHJ_ADDR_W] != 26'h0) rok_d = 1'b0;
  end

  // Read answer two edges after arvalid
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PGHJ_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rok_d ? rd_d : 32'h0000_0000;
        s_axi_rresp <= rok_d ? `PGHJ_RESP_OKAY : `PGHJ_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Override tables
  // ----------------------------------------------------------------
  reg [W-1:0] g_pullup_override_en, g_pullup_override_val, g_dir_override_en, g_dir_override_val, g_value_override_en, g_value_override_val, g_input_en_override_en, g_input_en_override_val;
  reg [W-1:0] h_pullup_override_en, h_pullup_override_val, h_dir_override_en, h_dir_override_val, h_value_override_en, h_value_override_val, h_input_en_override_en, h_input_en_override_val;
  reg [W-1:0] j_pullup_override_en, j_pullup_override_val, j_dir_override_en, j_dir_override_val, j_value_override_en, j_value_override_val, j_input_en_override_en, j_input_en_override_val;
  wire        osc_ext = async_timer_clk_sel & ext_clock_sel;
  wire        ck2_oe  = serial2_clk_out_en & sync2;
  always @* begin
    {g_pullup_override_en, g_pullup_override_val, g_dir_override_en, g_dir_override_val, g_value_override_en, g_value_override_val, g_input_en_override_en, g_input_en_override_val} = {8*W{1'b0}};
    {h_pullup_override_en, h_pullup_override_val, h_dir_override_en, h_dir_override_val, h_value_override_en, h_value_override_val, h_input_en_override_en, h_input_en_override_val} = {8*W{1'b0}};
    {j_pullup_override_en, j_pullup_override_val, j_dir_override_en, j_dir_override_val, j_value_override_en, j_value_override_val, j_input_en_override_en, j_input_en_override_val} = {8*W{1'b0}};
    // Port G bits 2..0 external memory strobes
    g_pullup_override_en[2:0] = {3{ext_mem_enable}};
    g_dir_override_en[2:0] = {3{ext_mem_enable}};
    g_dir_override_val[2:0] = 3'h7;
    g_value_override_en[2:0] = {3{ext_mem_enable}};
    g_value_override_val[2:0] = {ext_mem_ale, ext_mem_rd_strobe, ext_mem_wr_strobe};
    // Port G bit 3 oscillator output
    g_pullup_override_en[3] = osc_ext;
    g_dir_override_en[3] = osc_ext;
    g_input_en_override_en[3] = osc_ext;
    // Port G bit 4 oscillator input
    g_pullup_override_en[4] = async_timer_clk_sel;
    g_dir_override_en[4] = async_timer_clk_sel;
    g_input_en_override_en[4] = async_timer_clk_sel;
    g_input_en_override_val[4] = ext_clock_sel;
    // Port G bit 5 timer0 compare B, value only
    g_value_override_en[5] = timer0_cmp_b_en;
    g_value_override_val[5] = timer0_cmp_b_out;
    // Port H bits 6..3 compare outputs, value only
    h_value_override_en[6:3] = {timer2_cmp_b_en, timer4_cmp_en[2:0]};
    h_value_override_val[6:3] = {timer2_cmp_b_out, timer4_cmp_out[2:0]};
    // Port H bit 2 serial2 clock, synchronous only
    h_dir_override_en[2] = ck2_oe;
    h_dir_override_val[2] = 1'b1;
    h_value_override_en[2] = ck2_oe;
    h_value_override_val[2] = serial2_clk;
    // Port H bit 1 serial2 transmit
    h_pullup_override_en[1] = serial2_tx_enable;
    h_dir_override_en[1] = serial2_tx_enable;
    h_dir_override_val[1] = 1'b1;
    h_value_override_en[1] = serial2_tx_enable;
    h_value_override_val[1] = serial2_tx;
    // Port H bit 0 serial2 receive
    h_pullup_override_en[0] = serial2_rx_enable;
    h_pullup_override_val[0] = h_val_q[0] & ~global_pullup_disable;
    h_dir_override_en[0] = serial2_rx_enable;
    // Port J bits 6..0 pin-change inputs kept enabled
    j_input_en_override_en[6:0] = pin_change_mask & {7{pcie1}};
    j_input_en_override_val[6:0] = 7'h7F;
    // Port J bits 2..0 serial3 pins
    j_dir_override_en[2] = serial3_clk_out_en;
    j_dir_override_val[2] = 1'b1;
    j_value_override_en[2] = serial3_clk_out_en;
    j_value_override_val[2] = serial3_clk;
    j_pullup_override_en[1] = serial3_tx_enable;
    j_dir_override_en[1] = serial3_tx_enable;
    j_dir_override_val[1] = 1'b1;
    j_value_override_en[1] = serial3_tx_enable;
    j_value_override_val[1] = serial3_tx;
    j_pullup_override_en[0] = serial3_rx_enable;
    j_pullup_override_val[0] = j_val_q[0] & ~global_pullup_disable;
    j_dir_override_en[0] = serial3_rx_enable;
  end

  // ----------------------------------------------------------------
  // Per-bit merge of port settings and overrides
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      assign g_oe[i] = g_dir_override_en[i] ? g_dir_override_val[i] : g_dir_q[i];
      assign g_o[i]  = g_value_override_en[i] ? g_value_override_val[i] : g_val_q[i];
      assign g_pu[i] = g_pullup_override_en[i] ? g_pullup_override_val[i] : (g_val_q[i] & ~g_dir_q[i] & ~global_pullup_disable);
      assign g_ie[i] = g_input_en_override_en[i] ? g_input_en_override_val[i] : 1'b1;
      assign h_oe[i] = h_dir_override_en[i] ? h_dir_override_val[i] : h_dir_q[i];
      assign h_o[i]  = h_value_override_en[i] ? h_value_override_val[i] : h_val_q[i];
      assign h_pu[i] = h_pullup_override_en[i] ? h_pullup_override_val[i] : (h_val_q[i] & ~h_dir_q[i] & ~global_pullup_disable);
      assign h_ie[i] = h_input_en_override_en[i] ? h_input_en_override_val[i] : 1'b1;
      assign j_oe[i] = j_dir_override_en[i] ? j_dir_override_val[i] : j_dir_q[i];
      assign j_o[i]  = j_value_override_en[i] ? j_value_override_val[i] : j_val_q[i];
      assign j_pu[i] = j_pullup_override_en[i] ? j_pullup_override_val[i] : (j_val_q[i] & ~j_dir_q[i] & ~global_pullup_disable);
      assign j_ie[i] = j_input_en_override_en[i] ? j_input_en_override_val[i] : 1'b1;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registered pad and peripheral outputs
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      {pad_g_out, pad_g_oe, pad_g_pullup} <= {3*W{1'b0}};
      {pad_h_out, pad_h_oe, pad_h_pullup} <= {3*W{1'b0}};
      {pad_j_out, pad_j_oe, pad_j_pullup} <= {3*W{1'b0}};
      timer_osc_in <= 1'b0;
      timer_osc_out_oe <= 1'b0;
      timer4_count_in <= 1'b0;
      serial2_clk_in <= 1'b0;
      serial2_rx <= 1'b1;
      serial3_clk_in <= 1'b0;
      serial3_rx <= 1'b1;
      pin_change_src <= 7'h00;
    end else begin
      pad_g_out <= g_o;
      pad_g_oe <= g_oe;
      pad_g_pullup <= g_pu;
      pad_h_out <= h_o;
      pad_h_oe <= h_oe;
      pad_h_pullup <= h_pu;
      pad_j_out <= j_o;
      pad_j_oe <= j_oe;
      pad_j_pullup <= j_pu;
      timer_osc_in <= async_timer_clk_sel & g_ie[4] & pad_g_in[4];
      timer_osc_out_oe <= osc_ext & timer_osc_out;
      timer4_count_in <= pad_h_in[7];
      serial2_clk_in <= sync2 & ~h_dir_q[2] & pad_h_in[2];
      serial2_rx <= serial2_rx_enable ? pad_h_in[0] : 1'b1;
      serial3_clk_in <= ~j_dir_q[2] & pad_j_in[2];
      serial3_rx <= serial3_rx_enable ? pad_j_in[0] : 1'b1;
      pin_change_src <= pad_j_in[6:0] & j_ie[6:0];
    end
  end

endmodule // pghj_pin_mux
`default_nettype wire

// file: pghj_pin_mux_asserts.sv
// Checker for the port G/H/J override block.
// Assumes it is bound into pghj_pin_mux and sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module pghj_chk #(
  parameter W = 8
) (
  // Clock and reset
  input wire logic         aclk, aresetn,
  // Peripheral controls
  input wire logic         ext_mem_enable, ext_mem_ale, ext_mem_rd_strobe, ext_mem_wr_strobe,
  input wire logic         async_timer_clk_sel, ext_clock_sel, timer_osc_out, timer0_cmp_b_en,
  input wire logic         timer0_cmp_b_out, timer2_cmp_b_en, timer2_cmp_b_out,
  input wire logic         serial2_tx_enable, serial2_tx, serial2_rx_enable,
  input wire logic [2:0]   timer4_cmp_en, timer4_cmp_out,
  // Pads and peripheral inputs
  input wire logic [W-1:0] pad_g_in, pad_h_in, pad_g_out, pad_g_oe, pad_g_pullup,
  input wire logic [W-1:0] pad_h_out, pad_h_oe, pad_h_pullup,
  input wire logic         timer_osc_in, timer_osc_out_oe, timer4_count_in, serial2_rx
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ---------------------------------------------------------------
  // Pin override relations, one clock after their cause
  // ---------------------------------------------------------------
  a_mem_strobes: assert property (ext_mem_enable |=> pad_g_oe[2:0] == 3'h7 && pad_g_pullup[2:0] == 3'h0 &&
    pad_g_out[2:0] == {$past(ext_mem_ale), $past(ext_mem_rd_strobe), $past(ext_mem_wr_strobe)})
    else $error("memory strobes not on port G");
  a_osc_out_off: assert property (async_timer_clk_sel && ext_clock_sel |=> !pad_g_oe[3] && !pad_g_pullup[3] &&
    timer_osc_out_oe == $past(timer_osc_out)) else $error("oscillator output pin not released");
  a_osc_in_path: assert property (async_timer_clk_sel |=> !pad_g_oe[4] && !pad_g_pullup[4] &&
    timer_osc_in == ($past(ext_clock_sel) & $past(pad_g_in[4]))) else $error("oscillator input path wrong");
  a_cmp0_value: assert property (timer0_cmp_b_en |=> pad_g_out[5] == $past(timer0_cmp_b_out))
    else $error("timer0 compare value not on pin");
  a_count_src: assert property (1'h1 |=> timer4_count_in == $past(pad_h_in[7]))
    else $error("counting source not from pin");
  a_cmp_h_value: assert property (timer2_cmp_b_en && timer4_cmp_en == 3'h7 |=>
    pad_h_out[6:3] == {$past(timer2_cmp_b_out), $past(timer4_cmp_out)}) else $error("compare values not on port H");
  a_tx_drive: assert property (serial2_tx_enable |=> pad_h_oe[1] && !pad_h_pullup[1] &&
    pad_h_out[1] == $past(serial2_tx)) else $error("transmit pin not driven");
  a_rx_input: assert property (serial2_rx_enable |=> !pad_h_oe[0] && serial2_rx == $past(pad_h_in[0]))
    else $error("receive pin not an input");

  // Main scenarios reached
  c_mem: cover property (ext_mem_enable ##1 pad_g_oe[2:0] == 3'h7);
  c_osc: cover property (async_timer_clk_sel && ext_clock_sel);
  c_rx: cover property (serial2_rx_enable ##1 !serial2_rx);
endmodule // pghj_chk

bind pghj_pin_mux pghj_chk #(.W(W)) i_pghj_chk (.*);
`default_nettype wire

// file: pghj_pin_mux_bench.sv
// Self-checking bench for the port G/H/J override block.
// Assumes pghj_consts.vh on the include path and the board model pghj_pads.
`timescale 1ns/100ps
`default_nettype none
`include "pghj_consts.vh"
module pghj_pin_mux_bench;
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [7:0]  pad_g_in, pad_h_in, pad_j_in, pad_g_out, pad_g_oe, pad_g_pullup;
  wire logic [7:0]  pad_h_out, pad_h_oe, pad_h_pullup, pad_j_out, pad_j_oe, pad_j_pullup;
  logic [7:0]  ext_g = '0, ext_h = '0, ext_j = '0;
  logic        ext_mem_enable = 1'h0, ext_mem_ale = 1'h0, ext_mem_rd_strobe = 1'h0, ext_mem_wr_strobe = 1'h0;
  logic        async_timer_clk_sel = 1'h0, ext_clock_sel = 1'h0, timer_osc_out = 1'h0;
  logic        timer0_cmp_b_en = 1'h0, timer0_cmp_b_out = 1'h0, timer2_cmp_b_en = 1'h0, timer2_cmp_b_out = 1'h0;
  logic [2:0]  timer4_cmp_en = '0, timer4_cmp_out = '0;
  logic        serial2_clk_out_en = 1'h0, serial2_clk = 1'h0, serial2_tx_enable = 1'h0, serial2_tx = 1'h0;
  logic        serial2_rx_enable = 1'h0, serial3_clk_out_en = 1'h0, serial3_clk = 1'h0, serial3_tx_enable = 1'h0;
  logic        serial3_tx = 1'h0, serial3_rx_enable = 1'h0;
  logic [6:0]  pin_change_mask = '0;
  wire logic   timer_osc_in, timer_osc_out_oe, timer4_count_in, serial2_clk_in, serial2_rx, serial3_clk_in, serial3_rx;
  wire logic [6:0] pin_change_src;
  int          errors = 0, checked = 0;

  // ---------------------------------------------------------------
  // Design and board
  // ---------------------------------------------------------------
  pghj_pin_mux i_pghj_pin_mux (.*);
  pghj_pads i_pads_g (.out(pad_g_out), .oe(pad_g_oe), .pu(pad_g_pullup), .ext(ext_g), .lvl(pad_g_in));
  pghj_pads i_pads_h (.out(pad_h_out), .oe(pad_h_oe), .pu(pad_h_pullup), .ext(ext_h), .lvl(pad_h_in));
  pghj_pads i_pads_j (.out(pad_j_out), .oe(pad_j_oe), .pu(pad_j_pullup), .ext(ext_j), .lvl(pad_j_in));

  // 50 MHz clock
  initial begin
    forever #10 aclk = ~aclk;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic stop_test;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask

  // Let registered pin outputs settle after a change
  task automatic wt;
    repeat (3) @(posedge aclk);
    #1;
  endtask

  // One write: address and data offered together, held until taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (n >= 0) begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, er);
        n = -1;
      end else if (n > 40) begin
        errors++;
        stop_test();
      end
    end
  endtask

  // One read with expected data and response
  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (n >= 0) begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'h0;
        chk(s_axi_rdata, exp);
        chk(s_axi_rresp, er);
        n = -1;
      end else if (n > 40) begin
        errors++;
        stop_test();
      end
    end
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    #1;
    chk(pad_g_oe, 8'h00);
    chk(serial2_rx, 1'h1);
    rd(`PGHJ_ADDR_CTRL, 32'h0000_0000, `PGHJ_RESP_OKAY);
    rd(32'h0000_0030, 32'h0000_0000, `PGHJ_RESP_SLVERR);
    wr(`PGHJ_ADDR_G_PIN, 32'h0000_00FF, `PGHJ_RESP_SLVERR);
    wr(32'h0000_0002, 32'h0000_00FF, `PGHJ_RESP_SLVERR);
    // Memory strobes take over port G bits 2..0
    wr(`PGHJ_ADDR_G_VAL, 32'h0000_00FF, `PGHJ_RESP_OKAY);
    @(posedge aclk);
    {ext_mem_enable, ext_mem_ale, ext_mem_rd_strobe, ext_mem_wr_strobe} <= 4'hD;
    wt();
    chk(pad_g_oe, 8'h07);
    chk(pad_g_out, 8'hFD);
    chk(pad_g_pullup, 8'hF8);
    // Oscillator pins released from the port
    wr(`PGHJ_ADDR_G_DIR, 32'h0000_0018, `PGHJ_RESP_OKAY);
    @(posedge aclk);
    ext_mem_enable <= 1'h0;
    {async_timer_clk_sel, ext_clock_sel, timer_osc_out} <= 3'h7;
    ext_g <= 8'h10;
    wt();
    chk(pad_g_oe[4:3], 2'h0);
    chk(pad_g_pullup[4:3], 2'h0);
    chk({timer_osc_in, timer_osc_out_oe}, 2'h3);
    @(posedge aclk);
    ext_clock_sel <= 1'h0;
    wt();
    chk({pad_g_oe[4:3], timer_osc_in}, 3'h2);
    // Timer0 compare takes the value only
    wr(`PGHJ_ADDR_G_DIR, 32'h0000_0000, `PGHJ_RESP_OKAY);
    @(posedge aclk);
    async_timer_clk_sel <= 1'h0;
    {timer0_cmp_b_en, timer0_cmp_b_out} <= 2'h3;
    wt();
    chk({pad_g_oe[5], pad_g_out[5]}, 2'h1);
    wr(`PGHJ_ADDR_G_DIR, 32'h0000_0020, `PGHJ_RESP_OKAY);
    wt();
    chk(pad_g_oe[5], 1'h1);
    // Port H compare outputs and counting source
    wr(`PGHJ_ADDR_H_DIR, 32'h0000_0078, `PGHJ_RESP_OKAY);
    @(posedge aclk);
    {timer2_cmp_b_en, timer2_cmp_b_out, timer4_cmp_en, timer4_cmp_out} <= 8'hFD;
    ext_h <= 8'h80;
    wt();
    chk(pad_h_oe[7:3], 5'h0F);
    chk(pad_h_out[6:3], 4'hD);
    chk(timer4_count_in, 1'h1);
    wr(`PGHJ_ADDR_H_DIR, 32'h0000_0000, `PGHJ_RESP_OKAY);
    @(posedge aclk);
    ext_h <= 8'h04;
    wt();
    chk(pad_h_oe[6:3], 4'h0);
    chk(timer4_count_in, 1'h0);
    // Serial2 clock in sync mode, then with sync mode off
    wr(`PGHJ_ADDR_CTRL, 32'h0000_0002, `PGHJ_RESP_OKAY);
    wt();
    chk(serial2_clk_in, 1'h1);
    wr(`PGHJ_ADDR_H_VAL, 32'h0000_0003, `PGHJ_RESP_OKAY);
    @(posedge aclk);
    {serial2_clk_out_en, serial2_clk, serial2_tx_enable, serial2_tx} <= 4'hE;
    wt();
    chk(pad_h_oe[2:1], 2'h3);
    chk(pad_h_out[2:1], 2'h2);
    chk(pad_h_pullup[1], 1'h0);
    wr(`PGHJ_ADDR_CTRL, 32'h0000_0000, `PGHJ_RESP_OKAY);
    wt();
    chk({pad_h_oe[2], serial2_clk_in}, 2'h0);
    // Serial2 receiver forces an input with value-driven pull-up
    wr(`PGHJ_ADDR_H_DIR, 32'h0000_0001, `PGHJ_RESP_OKAY);
    @(posedge aclk);
    serial2_rx_enable <= 1'h1;
    ext_h <= 8'h00;
    wt();
    chk({pad_h_oe[0], pad_h_pullup[0], serial2_rx}, 3'h3);
    wr(`PGHJ_ADDR_CTRL, 32'h0000_0001, `PGHJ_RESP_OKAY);
    wt();
    chk({pad_h_pullup[0], serial2_rx}, 2'h0);
    // Port J pin-change sources and serial3 transmit
    wr(`PGHJ_ADDR_CTRL, 32'h0000_0004, `PGHJ_RESP_OKAY);
    @(posedge aclk);
    pin_change_mask <= 7'h7F;
    ext_j <= 8'hA5;
    wt();
    chk(pin_change_src, 7'h25);
    chk(pad_j_oe[7], 1'h0);
    @(posedge aclk);
    pin_change_mask <= 7'h0F;
    {serial3_tx_enable, serial3_tx} <= 2'h3;
    wt();
    chk(pin_change_src, 7'h27);
    chk({pad_j_oe[1], pad_j_out[1]}, 2'h3);
    @(posedge aclk);
    serial3_rx_enable <= 1'h1;
    wt();
    chk({pad_j_oe[0], pad_j_pullup[0], serial3_rx, serial3_clk_in}, 4'h3);
    rd(`PGHJ_ADDR_J_PIN, 32'h0000_00A7, `PGHJ_RESP_OKAY);
    stop_test();
  end
endmodule // pghj_pin_mux_bench
`default_nettype wire
